//--- rtl/flash_guard_pkg.sv
// Package for the flash write/erase lock guard.
// Assumes an 8-bit special function register bus on the system clock.
package flash_guard_pkg;

    // ************************************************************
    // Register addresses and fields
    // ************************************************************
    localparam logic [7:0] program_store_control_addr = 8'h8f;
    localparam logic [7:0] silicon_revision_id_addr   = 8'he2;
    localparam int         write_enable_bit           = 0;
    localparam int         erase_enable_bit           = 1;
    localparam logic [7:0] program_store_control_rst  = 8'h00;
    // Revision value arbitrary
    localparam logic [7:0] revision_id_default        = 8'h5a;

    // ************************************************************
    // Flash geometry
    // ************************************************************
    localparam int         addr_width = 16;
    localparam int         page_shift = 9;
    localparam int         page_width = addr_width - page_shift;
    localparam logic [7:0] lock_open  = 8'hff;

    // ************************************************************
    // Requesters and flash operations
    // ************************************************************
    typedef enum logic [1:0] {
        req_debug,
        req_unlocked_code,
        req_locked_code
    } requester_t;

    typedef enum logic [1:0] {
        op_read,
        op_write,
        op_erase
    } flash_op_t;

    typedef struct packed {
        logic                  valid;
        requester_t            who;
        flash_op_t             op;
        logic [addr_width-1:0] addr;
    } flash_req_t;

endpackage

//--- rtl/page_lock_map.sv
// Page lock decoder: tells whether an address falls in a locked page.
// Assumes the lock byte is already captured from the last flash byte.
`timescale 1ns/1ps
module page_lock_map #(
    parameter int addr_width = flash_guard_pkg::addr_width,
    parameter int page_shift = flash_guard_pkg::page_shift
) (
    input  wire logic [7:0]            lock_byte,
    input  wire logic [addr_width-1:0] addr,
    input  wire logic [addr_width-1:0] lock_page_addr,
    output logic                       page_locked
);
    localparam int pw = addr_width - page_shift;

    wire logic [7:0]    locked_count = ~lock_byte;
    wire logic [pw-1:0] page_num     = addr[addr_width-1:page_shift];
    wire logic [pw-1:0] lock_page    =
        lock_page_addr[addr_width-1:page_shift];
    wire logic [pw:0]   page_wide    = {1'b0, page_num};
    wire logic [pw:0]   count_wide   = (pw + 1)'(locked_count);

    wire logic low_locked  = page_wide < count_wide;
    wire logic byte_locked = (page_num == lock_page) &&
                             (lock_byte != flash_guard_pkg::lock_open);

    assign page_locked = low_locked || byte_locked;
endmodule

//--- rtl/flash_lock_guard.sv
// Flash write/erase lock guard with program store control and revision id.
// Assumes a single-cycle SFR bus and a flash controller on ref_clk.
// Assumes the lock byte value is fetched by the flash controller.
// Summary of operation
// - Code writes only while write enable set
// - Code erase needs write and erase enables
// - Last user flash byte is lock byte
// - Inverse lock byte counts locked pages
// - Lock byte page locked if any locked
// - Separate rules for three requesters
// - Readable 8-bit silicon revision field
`timescale 1ns/1ps
module flash_lock_guard #(
    parameter logic [7:0] revision_id =
        flash_guard_pkg::revision_id_default, // Value arbitrary
    parameter int         flash_bytes = 2048
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         sfr_wr,
    input  wire logic                         sfr_rd,
    input  wire logic [7:0]                   sfr_addr,
    input  wire logic [7:0]                   sfr_wdata,
    output logic      [7:0]                   sfr_rdata,
    input  wire logic                         lock_load,
    input  wire logic [7:0]                   lock_value,
    input  wire flash_guard_pkg::flash_req_t  req,
    output logic                              grant,
    output logic                              deny,
    output logic      [7:0]                   lock_byte_out
);
    // ************************************************************
    // Local constants
    // ************************************************************
    localparam int            aw        = flash_guard_pkg::addr_width;
    localparam int            pg_shift  = flash_guard_pkg::page_shift;
    localparam logic [aw-1:0] lock_addr = aw'(flash_bytes - 1);
    localparam int            we_bit    =
        flash_guard_pkg::write_enable_bit;
    localparam int            ee_bit    =
        flash_guard_pkg::erase_enable_bit;
    localparam logic [7:0]    psc_mask  =
        8'(1 << we_bit) | 8'(1 << ee_bit);
    localparam int            n_who     =
        2 ** $bits(flash_guard_pkg::requester_t);
    localparam int            who_dbg   =
        int'(flash_guard_pkg::req_debug);
    localparam int            who_unl   =
        int'(flash_guard_pkg::req_unlocked_code);
    localparam int            who_lkd   =
        int'(flash_guard_pkg::req_locked_code);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] program_store_control_reg;
    logic [7:0] program_store_control_next;
    logic [7:0] lock_byte_reg;
    logic [7:0] lock_byte_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       grant_reg;
    logic       grant_next;
    logic       deny_reg;
    logic       deny_next;

    // ************************************************************
    // Register decode
    // ************************************************************
    wire logic sel_psc   =
        sfr_addr == flash_guard_pkg::program_store_control_addr;
    wire logic sel_rev   =
        sfr_addr == flash_guard_pkg::silicon_revision_id_addr;
    wire logic psc_write = sfr_wr && sel_psc;

    assign program_store_control_next =
        psc_write ? (sfr_wdata & psc_mask) : program_store_control_reg;

    // ************************************************************
    // Program store enables
    // ************************************************************
    wire logic write_enable = program_store_control_reg[we_bit];
    wire logic erase_enable = program_store_control_reg[ee_bit];

    wire logic sw_write_en  = write_enable;
    wire logic sw_erase_en  = write_enable && erase_enable;

    // ************************************************************
    // Register read data
    // ************************************************************
    wire logic [7:0] psc_rd_word =
        sel_psc ? program_store_control_reg : 8'h00;
    wire logic [7:0] rev_rd_word =
        sel_rev ? revision_id : 8'h00;
    wire logic [7:0] rd_word     = psc_rd_word | rev_rd_word;

    assign rdata_next = sfr_rd ? rd_word : rdata_reg;

    // ************************************************************
    // Lock byte and page map
    // ************************************************************
    // Lock byte capture
    assign lock_byte_next = lock_load ? lock_value : lock_byte_reg;

    wire logic any_locked   =
        lock_byte_reg != flash_guard_pkg::lock_open;
    wire logic at_lock_byte = req.addr == lock_addr;
    logic      page_locked;

    page_lock_map #(
        .addr_width (aw),
        .page_shift (pg_shift)
    ) u_map (
        .lock_byte      (lock_byte_reg),
        .addr           (req.addr),
        .lock_page_addr (lock_addr),
        .page_locked    (page_locked)
    );

    // ************************************************************
    // Request decode
    // ************************************************************
    wire logic is_read  = req.op == flash_guard_pkg::op_read;
    wire logic is_write = req.op == flash_guard_pkg::op_write;
    wire logic is_erase = req.op == flash_guard_pkg::op_erase;

    // ************************************************************
    // Permission table, one entry per requester code
    // ************************************************************
    wire logic [n_who-1:0] may_read;
    wire logic [n_who-1:0] may_write;
    wire logic [n_who-1:0] may_erase;

    for (genvar w = 0; w < n_who; w++) begin : g_who
        if (w == who_dbg) begin : g_dbg
            // Locked part: only erase of the lock byte
            assign may_read[w]  = !any_locked;
            assign may_write[w] = !any_locked;
            assign may_erase[w] = !any_locked || at_lock_byte;
        end else if (w == who_unl) begin : g_unl
            assign may_read[w]  = !page_locked;
            assign may_write[w] = !page_locked && sw_write_en;
            assign may_erase[w] = !page_locked && sw_erase_en;
        end else if (w == who_lkd) begin : g_lkd
            assign may_read[w]  = 1'b1;
            assign may_write[w] = sw_write_en;
            assign may_erase[w] = sw_erase_en;
        end else begin : g_bad
            // Unused code is refused
            assign may_read[w]  = 1'b0;
            assign may_write[w] = 1'b0;
            assign may_erase[w] = 1'b0;
        end
    end

    // ************************************************************
    // Access decision
    // ************************************************************
    wire logic read_ok  = is_read  && may_read[req.who];
    wire logic write_ok = is_write && may_write[req.who];
    wire logic erase_ok = is_erase && may_erase[req.who];

    wire logic allow = read_ok || write_ok || erase_ok;

    assign grant_next = req.valid && allow;
    assign deny_next  = req.valid && !allow;

    // ************************************************************
    // Program store control register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            program_store_control_reg <=
                flash_guard_pkg::program_store_control_rst;
        end else begin
            program_store_control_reg <= program_store_control_next;
        end
    end

    // ************************************************************
    // Lock byte register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lock_byte_reg <= flash_guard_pkg::lock_open;
        end else begin
            lock_byte_reg <= lock_byte_next;
        end
    end

    // ************************************************************
    // Read data register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Answer registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            grant_reg <= 1'b0;
            deny_reg  <= 1'b0;
        end else begin
            grant_reg <= grant_next;
            deny_reg  <= deny_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sfr_rdata     = rdata_reg;
    assign grant         = grant_reg;
    assign deny          = deny_reg;
    assign lock_byte_out = lock_byte_reg;
endmodule

//--- verification/flash_lock_guard_sva.sv
// Port checker for the flash lock guard.
// Assumes it is bound to flash_lock_guard.
`timescale 1ns/1ps
module flash_lock_guard_sva #(
    parameter logic [7:0] revision_id = 8'h5a, // Value arbitrary
    parameter int         flash_bytes = 2048
) (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        sfr_wr,
    input wire logic                        sfr_rd,
    input wire logic [7:0]                  sfr_addr,
    input wire logic [7:0]                  sfr_wdata,
    input wire logic [7:0]                  sfr_rdata,
    input wire logic                        lock_load,
    input wire logic [7:0]                  lock_value,
    input wire flash_guard_pkg::flash_req_t req,
    input wire logic                        grant,
    input wire logic                        deny,
    input wire logic [7:0]                  lock_byte_out
);
    // ****
    // Helpers
    // ****
    localparam logic [6:0] lp = 7'((flash_bytes - 1) >> 9);
    logic [1:0] ctl_reg;
    wire logic dbg = req.who == flash_guard_pkg::req_debug;
    wire logic unl = req.who == flash_guard_pkg::req_unlocked_code;
    wire logic sw  = req.valid && !dbg;
    wire logic [6:0] pg = req.addr[15:9];
    wire logic sh  = lock_byte_out != 8'hff;
    always_ff @(posedge ref_clk) begin
        if (rst) ctl_reg <= 2'h0;
        else if (sfr_wr && sfr_addr == 8'h8f) ctl_reg <= sfr_wdata[1:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_deny; ##1 deny && !grant; endsequence
    // ****
    // Properties
    // ****
    property p_ans; req.valid |=> grant != deny; endproperty
    property p_quiet; !req.valid |=> !grant && !deny; endproperty
    property p_rev; sfr_rd && sfr_addr == 8'he2 |=> sfr_rdata == revision_id;
    endproperty
    property p_load; lock_load |=> lock_byte_out == $past(lock_value);
    endproperty
    property p_we; sw && req.op == flash_guard_pkg::op_write && !ctl_reg[0]
        |-> s_deny; endproperty
    property p_ee; sw && req.op == flash_guard_pkg::op_erase && ctl_reg != 3
        |-> s_deny; endproperty
    property p_dbg; req.valid && dbg && sh
        && req.op == flash_guard_pkg::op_read |-> s_deny; endproperty
    property p_pg0; req.valid && unl && sh && pg == 0 |-> s_deny; endproperty
    property p_lkp; req.valid && unl && sh && pg == lp |-> s_deny; endproperty
    a_ans: assert property (p_ans) else $error("bad answer");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_rev: assert property (p_rev) else $error("bad revision");
    a_load: assert property (p_load) else $error("bad lock byte");
    a_we: assert property (p_we) else $error("write allowed");
    a_ee: assert property (p_ee) else $error("erase allowed");
    a_dbg: assert property (p_dbg) else $error("debug read");
    a_pg0: assert property (p_pg0) else $error("page 0 open");
    a_lkp: assert property (p_lkp) else $error("lock page open");
endmodule

//--- verification/flash_lock_guard_tb_top.sv
// Testbench for the flash lock guard.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module flash_lock_guard_tb_top;
    localparam int fb = 2048;
    logic ref_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, lock_load = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, lock_value = 0;
    logic [7:0] sfr_rdata, lock_byte_out, lk = 8'hff;
    logic grant, deny;
    logic [1:0] ctl = 0;
    flash_guard_pkg::flash_req_t req = '0;
    int bad_count = 0, n_checks = 0, cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    flash_lock_guard #(.flash_bytes(fb)) dut_u (.ref_clk, .rst, .sfr_wr,
        .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .lock_load,
        .lock_value, .req, .grant, .deny, .lock_byte_out);
    task automatic pulse(input logic [2:0] k, input logic [7:0] a, d);
        @(posedge ref_clk);
        {lock_load, sfr_rd, sfr_wr} <= k;
        sfr_addr <= a; sfr_wdata <= d; lock_value <= d;
        @(posedge ref_clk);
        {lock_load, sfr_rd, sfr_wr} <= 3'h0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        pulse(3'h1, a, d);
        if (a == 8'h8f) ctl = d[1:0];
    endtask
    task automatic rd(input logic [7:0] a, e);
        pulse(3'h2, a, 8'h00);
        `CHK("rdata", e, sfr_rdata)
    endtask
    task automatic ld(input logic [7:0] v);
        pulse(3'h4, 8'h00, v);
        lk = v;
        `CHK("lock", v, lock_byte_out)
    endtask
    function automatic logic ok(flash_guard_pkg::flash_req_t r);
        logic [6:0] pg;
        logic lkd;
        logic [1:0] o;
        pg = r.addr[15:9];
        o = r.op;
        lkd = {1'b0, pg} < ~lk || (lk != 8'hff && pg == 7'((fb - 1) >> 9));
        if (r.who == flash_guard_pkg::req_debug)
            return lk == 8'hff || (o == 2'h2 && r.addr == 16'(fb - 1));
        return (o == 2'h0 || ctl[0]) && (o != 2'h2 || ctl[1])
            && !(r.who == flash_guard_pkg::req_unlocked_code && lkd);
    endfunction
    task automatic ask(input flash_guard_pkg::flash_req_t r);
        @(posedge ref_clk);
        req <= r;
        @(posedge ref_clk);
        req.valid <= 1'b0;
        #1;
        `CHK("grant", ok(r), grant)
        `CHK("deny", !ok(r), deny)
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize;
        end
    end
    initial begin
        flash_guard_pkg::flash_req_t r;
        void'($urandom(60));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        `CHK("lock rst", 8'hff, lock_byte_out)
        `CHK("rdata rst", 8'h00, sfr_rdata)
        `CHK("grant rst", 1'b0, grant)
        `CHK("deny rst", 1'b0, deny)
        rd(8'he2, flash_guard_pkg::revision_id_default);
        wr(8'he2, 8'h00);
        rd(8'he2, flash_guard_pkg::revision_id_default);
        rd(8'h8f, 8'h00);
        rd(8'h80, 8'h00);
        wr(8'h8f, 8'hff);
        rd(8'h8f, 8'h03);
        ld(8'hfe);
        for (int i = 0; i < 3; i++) ask({1'b1, 2'h1, 2'h0, 16'h01ff << i});
        ask({1'b1, 2'h0, 2'h2, 16'h07ff});
        repeat (400) begin
            case ($urandom % 4)
                0: wr(8'h8f, 8'($urandom));
                1: ld(($urandom % 2) ? 8'hff : 8'($urandom));
                default: begin
                    r.valid = 1'b1;
                    r.who = flash_guard_pkg::requester_t'($urandom % 3);
                    r.op = flash_guard_pkg::flash_op_t'($urandom % 3);
                    r.addr = ($urandom % 2) ? 16'h07ff : 16'($urandom % fb);
                    ask(r);
                end
            endcase
        end
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        ctl = 2'h0;
        lk = 8'hff;
        #1;
        `CHK("lock rst2", 8'hff, lock_byte_out)
        rd(8'h8f, 8'h00);
        ask({1'b1, 2'h1, 2'h1, 16'h0400});
        summarize;
    end
endmodule
bind flash_lock_guard flash_lock_guard_sva #(.flash_bytes(flash_bytes),
    .revision_id(revision_id)) chk_u (.ref_clk, .rst, .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .lock_load, .lock_value, .req,
    .grant, .deny, .lock_byte_out);
